// ---- logic/cpu_addressing_mode_unit.v ----
// Opcode decode, operand address generation, branch target and unsigned multiply
`timescale 1ns/1ps
// Function
// - Opcode map covers 62 instructions, the legacy set plus unsigned multiply.
// - Multiply accumulator by index; high byte to index, low byte to accumulator.
// - Exactly eight addressing modes are decoded.
// - Inherent instructions are one byte and produce no operand address.
// - Immediate instructions are two bytes; second byte is the literal operand.
// - Direct is two bytes, three for bit-test branches; high address byte forced to zero.
// - Extended is three bytes; second byte high address, third low.
// - Indexed no offset is one byte; address is zero-extended index.
// - Indexed 8-bit offset is two bytes; index plus unsigned byte.
// - Indexed 16-bit offset is three bytes; index plus high-then-low offset.
// - Branch taken adds sign-extended offset to address of next instruction.
// - Branch not taken continues at the instruction after the branch.
// - Every opcode falls into one of five instruction groups.
`include "addr_mode_defines.vh"
module cpu_addressing_mode_unit
(
  input  wire        clk_sys,
  input  wire        rst,
  input  wire        decode_req,
  input  wire [7:0]  opcode,
  input  wire [7:0]  operand1,
  input  wire [7:0]  operand2,
  input  wire [15:0] pc_of_opcode,
  input  wire [7:0]  acc_in,
  input  wire [7:0]  idx_in,
  input  wire        branch_cond,
  output reg         decode_valid,
  output reg  [2:0]  addr_mode,
  output reg  [2:0]  instr_group,
  output reg  [1:0]  instr_length,
  output reg         has_ea,
  output reg  [15:0] eff_addr,
  output reg  [7:0]  imm_data,
  output reg         is_branch,
  output reg         branch_taken,
  output reg  [15:0] next_pc,
  output reg         is_multiply,
  output reg  [7:0]  acc_out,
  output reg  [7:0]  idx_out,
  output reg         illegal_op
);

  // Mode from opcode column; bit ops in 0x0-0x1 rows use direct or direct+relative
  function [2:0] mode_of;
    input [7:0] op;
    begin
      case (op[7:4])
        4'h0: mode_of = `MODE_DIR;
        4'h1: mode_of = `MODE_DIR;
        4'h2: mode_of = `MODE_REL;
        4'h3: mode_of = `MODE_DIR;
        4'h4: mode_of = `MODE_INH;
        4'h5: mode_of = `MODE_INH;
        4'h6: mode_of = `MODE_IX1;
        4'h7: mode_of = `MODE_IX;
        4'h8: mode_of = `MODE_INH;
        4'h9: mode_of = `MODE_INH;
        4'ha:
        begin
          if (op[3:0] == 4'hd)
            mode_of = `MODE_REL;
          else
            mode_of = `MODE_IMM;
        end
        4'hb: mode_of = `MODE_DIR;
        4'hc: mode_of = `MODE_EXT;
        4'hd: mode_of = `MODE_IX2;
        4'he: mode_of = `MODE_IX1;
        4'hf: mode_of = `MODE_IX;
        default: mode_of = `MODE_INH;
      endcase
    end
  endfunction

  // Jumps and subroutine calls share the memory columns with the register/memory group
  function [2:0] group_of;
    input [7:0] op;
    begin
      case (op[7:4])
        4'h0: group_of = `GRP_BIT;
        4'h1: group_of = `GRP_BIT;
        4'h2: group_of = `GRP_JUMP;
        4'h3: group_of = `GRP_RMW;
        4'h4:
        begin
          if (op == `UNSIGNED_MULTIPLY_OP)
            group_of = `GRP_REGMEM;
          else
            group_of = `GRP_RMW;
        end
        4'h5: group_of = `GRP_RMW;
        4'h6: group_of = `GRP_RMW;
        4'h7: group_of = `GRP_RMW;
        4'h8: group_of = `GRP_CTRL;
        4'h9: group_of = `GRP_CTRL;
        default:
        begin
          case (op[3:0])
            4'hc, 4'hd: group_of = `GRP_JUMP;
            default: group_of = `GRP_REGMEM;
          endcase
        end
      endcase
    end
  endfunction

  // Read-modify-write columns share the same unused slots
  function rmw_gap_of;
    input [3:0] lo;
    begin
      case (lo)
        4'h1, 4'h2, 4'h5, 4'hb, 4'he: rmw_gap_of = 1'b1;
        default: rmw_gap_of = 1'b0;
      endcase
    end
  endfunction

  // Plain branches and bit-test branches both end in a relative offset
  function is_branch_of;
    input [7:0] op;
    begin
      is_branch_of = (mode_of(op) == `MODE_REL) || (op[7:4] == 4'h0);
    end
  endfunction

  // Holes in the legacy map plus the multiply slot; holes still decode by column
  function legal_of;
    input [7:0] op;
    begin
      case (op[7:4])
        4'h3, 4'h6, 4'h7: legal_of = !rmw_gap_of(op[3:0]);
        4'h4, 4'h5: legal_of = (op == `UNSIGNED_MULTIPLY_OP) || !rmw_gap_of(op[3:0]);
        4'h8:
        begin
          case (op[3:0])
            4'h0, 4'h1, 4'h3, 4'he, 4'hf: legal_of = 1'b1;
            default: legal_of = 1'b0;
          endcase
        end
        4'h9:
        begin
          case (op[3:0])
            4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'hf: legal_of = 1'b1;
            default: legal_of = 1'b0;
          endcase
        end
        4'ha:
        begin
          case (op[3:0])
            4'h7, 4'hc, 4'he: legal_of = 1'b0;
            default: legal_of = 1'b1;
          endcase
        end
        default: legal_of = 1'b1;
      endcase
    end
  endfunction

  reg  [2:0]  mode_nxt;
  reg  [1:0]  len_nxt;
  reg  [15:0] ea_nxt;
  reg         has_ea_nxt;
  reg         bit_branch;
  reg  [15:0] seq_pc;
  reg  [7:0]  rel_off;
  wire [15:0] product;
  reg         branch_nxt;
  reg         taken_nxt;
  reg  [2:0]  group_nxt;
  reg         illegal_nxt;
  reg         mul_nxt;
  reg  [15:0] npc_nxt;
  reg  [7:0]  acc_nxt;
  reg  [7:0]  idx_nxt;

  // Multiplier is sized to the full 16-bit product so no high bits are lost
  assign product = acc_in * idx_in;

  always @*
  begin
    mode_nxt   = mode_of(opcode);
    bit_branch = (opcode[7:4] == 4'h0);
    len_nxt    = 2'd1;
    ea_nxt     = 16'h0000;
    has_ea_nxt = 1'b1;
    rel_off    = operand1;
    case (mode_nxt)
      `MODE_INH:
      begin
        len_nxt    = 2'd1;
        has_ea_nxt = 1'b0;
      end
      `MODE_IMM:
      begin
        len_nxt    = 2'd2;
        has_ea_nxt = 1'b0;
      end
      `MODE_DIR:
      begin
        len_nxt = bit_branch ? 2'd3 : 2'd2;
        ea_nxt  = {`ZERO_PAGE_HI, operand1};
        rel_off = operand2;
      end
      `MODE_EXT:
      begin
        len_nxt = 2'd3;
        ea_nxt  = {operand1, operand2};
      end
      `MODE_IX:
      begin
        len_nxt = 2'd1;
        ea_nxt  = {`ZERO_PAGE_HI, idx_in};
      end
      `MODE_IX1:
      begin
        len_nxt = 2'd2;
        ea_nxt  = {8'h00, idx_in} + {8'h00, operand1};
      end
      `MODE_IX2:
      begin
        len_nxt = 2'd3;
        ea_nxt  = {operand1, operand2} + {8'h00, idx_in};
      end
      `MODE_REL:
      begin
        len_nxt    = 2'd2;
        has_ea_nxt = 1'b0;
      end
      default:
      begin
        len_nxt = 2'd1;
      end
    endcase
    seq_pc = pc_of_opcode + {14'h0000, len_nxt};
  end

  // Branch reach is measured from the next instruction, so the offset is added to seq_pc
  always @*
  begin
    branch_nxt  = is_branch_of(opcode);
    taken_nxt   = branch_nxt && branch_cond;
    group_nxt   = group_of(opcode);
    illegal_nxt = !legal_of(opcode);
    mul_nxt     = (opcode == `UNSIGNED_MULTIPLY_OP);
    if (taken_nxt)
      npc_nxt = seq_pc + {{8{rel_off[7]}}, rel_off};
    else
      npc_nxt = seq_pc;
    // Only the multiply opcode replaces A and X; every other opcode passes them through
    if (mul_nxt)
    begin
      idx_nxt = product[15:8];
      acc_nxt = product[7:0];
    end
    else
    begin
      idx_nxt = idx_in;
      acc_nxt = acc_in;
    end
  end

  // Every field loads on the same edge so the core never sees a half-updated decode
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      decode_valid <= 1'b0;
      addr_mode    <= `MODE_INH;
      instr_group  <= `GRP_CTRL;
      instr_length <= 2'd1;
      has_ea       <= 1'b0;
      eff_addr     <= 16'h0000;
      imm_data     <= 8'h00;
      is_branch    <= 1'b0;
      branch_taken <= 1'b0;
      next_pc      <= 16'h0000;
      is_multiply  <= 1'b0;
      acc_out      <= 8'h00;
      idx_out      <= 8'h00;
      illegal_op   <= 1'b0;
    end
    else
    begin
      decode_valid <= decode_req;
      if (decode_req)
      begin
        addr_mode    <= mode_nxt;
        instr_group  <= group_nxt;
        instr_length <= len_nxt;
        has_ea       <= has_ea_nxt;
        eff_addr     <= ea_nxt;
        imm_data     <= operand1;
        is_branch    <= branch_nxt;
        branch_taken <= taken_nxt;
        next_pc      <= npc_nxt;
        is_multiply  <= mul_nxt;
        acc_out      <= acc_nxt;
        idx_out      <= idx_nxt;
        illegal_op   <= illegal_nxt;
      end
    end
  end

endmodule // cpu_addressing_mode_unit

// ---- logic/addr_mode_defines.vh ----
// Constants for the operand addressing mode unit
`ifndef ADDR_MODE_DEFINES_VH
`define ADDR_MODE_DEFINES_VH
`define INSTR_COUNT       8'd62
`define MODE_INH          3'd0
`define MODE_IMM          3'd1
`define MODE_DIR          3'd2
`define MODE_EXT          3'd3
`define MODE_IX           3'd4
`define MODE_IX1          3'd5
`define MODE_IX2          3'd6
`define MODE_REL          3'd7
`define GRP_REGMEM        3'd0
`define GRP_RMW           3'd1
`define GRP_JUMP          3'd2
`define GRP_BIT           3'd3
`define GRP_CTRL          3'd4
`define UNSIGNED_MULTIPLY_OP 8'h42
`define ZERO_PAGE_HI      8'h00
`endif

// ---- testbench/am_chk.sv ----
// Port assertions for the addressing mode unit
`timescale 1ns/1ps
`include "addr_mode_defines.vh"
module am_chk
(
  input logic        clk_sys,
  input logic        rst,
  input logic        decode_req,
  input logic        branch_cond,
  input logic        decode_valid,
  input logic        has_ea,
  input logic        is_branch,
  input logic        branch_taken,
  input logic        is_multiply,
  input logic        illegal_op,
  input logic [7:0]  opcode,
  input logic [7:0]  operand1,
  input logic [7:0]  operand2,
  input logic [7:0]  acc_in,
  input logic [7:0]  idx_in,
  input logic [7:0]  imm_data,
  input logic [7:0]  acc_out,
  input logic [7:0]  idx_out,
  input logic [15:0] pc_of_opcode,
  input logic [15:0] eff_addr,
  input logic [15:0] next_pc,
  input logic [2:0]  addr_mode,
  input logic [2:0]  instr_group,
  input logic [1:0]  instr_length
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire [15:0] rel_off = {{8{operand1[7]}}, operand1};
  wire [15:0] bit_off = {{8{operand2[7]}}, operand2};
  wire [3:0]  col     = opcode[7:4];
  valid_pulse_a: assert property (decode_req |=> decode_valid)
    else $error("No valid after request");
  output_hold_a: assert property (!decode_req |=> $stable(eff_addr) && !decode_valid)
    else $error("Outputs moved without request");
  inh_length_a: assert property (decode_req && col == 4'h4 |=> instr_length == 2'd1 && !has_ea)
    else $error("Inherent form wrong");
  imm_data_a: assert property (decode_req && opcode == 8'ha6 |=> imm_data == $past(operand1))
    else $error("Immediate byte wrong");
  dir_page_a: assert property (decode_req && col == 4'hb |=> eff_addr == {8'h00, $past(operand1)})
    else $error("Direct address wrong");
  ext_addr_a: assert property (decode_req && col == 4'hc |=> eff_addr == {$past(operand1), $past(operand2)})
    else $error("Extended address wrong");
  ix0_addr_a: assert property (decode_req && col == 4'hf |=> eff_addr == {8'h00, $past(idx_in)})
    else $error("Indexed address wrong");
  ix1_sum_a: assert property (decode_req && col == 4'he |=> eff_addr == $past(operand1) + $past(idx_in))
    else $error("Short offset sum wrong");
  ix2_sum_a: assert property (decode_req && col == 4'hd |=>
    eff_addr == {$past(operand1), $past(operand2)} + $past(idx_in)) else $error("Long offset sum wrong");
  rel_target_a: assert property (decode_req && col == 4'h2 |=> is_branch && instr_group == `GRP_JUMP &&
    next_pc == $past(pc_of_opcode) + 16'd2 + ($past(branch_cond) ? $past(rel_off) : 16'h0000))
    else $error("Branch target wrong");
  product_split_a: assert property (decode_req && opcode == `UNSIGNED_MULTIPLY_OP |=>
    {idx_out, acc_out} == $past(acc_in) * $past(idx_in)) else $error("Product split wrong");
  ext_mode_a: assert property (decode_req && col == 4'hc |=> addr_mode == `MODE_EXT)
    else $error("Extended mode code wrong");
  taken_flag_a: assert property (decode_req && col == 4'h2 |=> branch_taken == $past(branch_cond))
    else $error("Branch taken flag wrong");
  bit_branch_a: assert property (decode_req && col == 4'h0 |=> instr_length == 2'd3 && is_branch &&
    next_pc == $past(pc_of_opcode) + 16'd3 + ($past(branch_cond) ? $past(bit_off) : 16'h0000))
    else $error("Bit branch target wrong");
  multiply_flag_a: assert property (decode_req |=> is_multiply == ($past(opcode) == `UNSIGNED_MULTIPLY_OP))
    else $error("Multiply flag wrong");
  illegal_slot_a: assert property (decode_req && opcode == 8'h31 |=> illegal_op)
    else $error("Illegal slot not flagged");
endmodule // am_chk
bind cpu_addressing_mode_unit am_chk am_chk_inst (.clk_sys, .rst, .decode_req, .branch_cond, .decode_valid,
  .has_ea, .is_branch, .branch_taken, .is_multiply, .illegal_op, .opcode, .operand1, .operand2, .acc_in,
  .idx_in, .imm_data, .acc_out, .idx_out, .pc_of_opcode, .eff_addr, .next_pc, .addr_mode, .instr_group,
  .instr_length);

// ---- testbench/prog_memory.sv ----
// Program memory model handing the opcode and its two following bytes
`timescale 1ns/1ps
module prog_memory
(
  input  logic [15:0] addr,
  output logic [7:0]  byte0,
  output logic [7:0]  byte1,
  output logic [7:0]  byte2
);
  logic [7:0] mem [0:65535];
  // Address wraps at the top of memory, as the program counter does
  assign byte0 = mem[addr];
  assign byte1 = mem[addr + 16'h0001];
  assign byte2 = mem[addr + 16'h0002];
endmodule // prog_memory

// ---- testbench/tb_cpu_addressing_mode_unit.sv ----
// Self-checking bench for the addressing mode unit
`timescale 1ns/1ps
`include "addr_mode_defines.vh"
module tb_cpu_addressing_mode_unit;
  logic clk_sys = 0, rst = 1, decode_req = 0, branch_cond = 0;
  logic [7:0] acc_in = 8'h00, idx_in = 8'h00, b0, b1, b2;
  logic [15:0] pc_r = 16'h0000;
  logic decode_valid, has_ea, is_branch, branch_taken, is_multiply, illegal_op;
  logic [2:0] addr_mode, instr_group;
  logic [1:0] instr_length;
  logic [15:0] eff_addr, next_pc;
  logic [7:0] imm_data, acc_out, idx_out;
  int failures = 0, compares = 0;
  always #10 clk_sys = ~clk_sys;
  prog_memory prog_memory_inst (.addr(pc_r), .byte0(b0), .byte1(b1), .byte2(b2));
  cpu_addressing_mode_unit cpu_addressing_mode_unit_inst (.clk_sys(clk_sys), .rst(rst), .decode_req(decode_req),
    .opcode(b0), .operand1(b1), .operand2(b2), .pc_of_opcode(pc_r), .acc_in(acc_in), .idx_in(idx_in),
    .branch_cond(branch_cond), .decode_valid(decode_valid), .addr_mode(addr_mode), .instr_group(instr_group),
    .instr_length(instr_length), .has_ea(has_ea), .eff_addr(eff_addr), .imm_data(imm_data),
    .is_branch(is_branch), .branch_taken(branch_taken), .next_pc(next_pc), .is_multiply(is_multiply),
    .acc_out(acc_out), .idx_out(idx_out), .illegal_op(illegal_op));
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Instruction is placed in memory first; the request then waits one edge for its answer
  task issue(input logic [15:0] pc, input logic [7:0] op, o1, o2, a, x, input logic c);
    @(posedge clk_sys);
    #1;
    prog_memory_inst.mem[pc] = op;
    prog_memory_inst.mem[pc + 16'h0001] = o1;
    prog_memory_inst.mem[pc + 16'h0002] = o2;
    pc_r = pc; acc_in = a; idx_in = x; branch_cond = c; decode_req = 1;
    @(posedge clk_sys);
    #1;
    decode_req = 0;
    chk(decode_valid, 1);
  endtask
  task t_inherent;
    issue(16'h0100, 8'h4c, 8'h00, 8'h00, 8'h00, 8'h00, 0);
    chk(addr_mode, `MODE_INH);
    chk(instr_length, 1);
    chk(has_ea, 0);
    chk(instr_group, `GRP_RMW);
    chk(illegal_op, 1'h0);
    chk(is_multiply, 1'h0);
    issue(16'h0101, 8'h9d, 8'h00, 8'h00, 8'h00, 8'h00, 0);
    chk(instr_group, `GRP_CTRL);
    issue(16'h0102, 8'h31, 8'h00, 8'h00, 8'h00, 8'h00, 0);
    chk(illegal_op, 1'h1);
  endtask
  task t_imm_dir;
    issue(16'h0200, 8'ha6, 8'h5a, 8'h00, 8'h00, 8'h00, 0);
    chk(addr_mode, `MODE_IMM);
    chk(imm_data, 8'h5a);
    chk(instr_length, 2);
    chk(instr_group, `GRP_REGMEM);
    issue(16'h0210, 8'hb6, 8'h80, 8'h00, 8'h00, 8'h00, 0);
    chk(addr_mode, `MODE_DIR);
    chk(eff_addr, 16'h0080);
    chk(is_branch, 1'h0);
    chk(instr_length, 2);
  endtask
  task t_ext_ix2;
    issue(16'h0300, 8'hc6, 8'h12, 8'h34, 8'h00, 8'h00, 0);
    chk(addr_mode, `MODE_EXT);
    chk(eff_addr, 16'h1234);
    chk(instr_length, 3);
    issue(16'h0310, 8'hd6, 8'h12, 8'hf0, 8'h00, 8'h20, 0);
    chk(addr_mode, `MODE_IX2);
    chk(eff_addr, 16'h1310);
    chk(instr_length, 3);
    issue(16'h0320, 8'hcc, 8'h12, 8'h34, 8'h00, 8'h00, 0);
    chk(instr_group, `GRP_JUMP);
  endtask
  task t_indexed;
    issue(16'h0400, 8'hf6, 8'h00, 8'h00, 8'h00, 8'h9a, 0);
    chk(addr_mode, `MODE_IX);
    chk(eff_addr, 16'h009a);
    chk(instr_length, 1);
    issue(16'h0410, 8'he6, 8'hff, 8'h00, 8'h00, 8'hff, 0);
    chk(addr_mode, `MODE_IX1);
    chk(eff_addr, 16'h01fe);
    chk(instr_length, 2);
  endtask
  task t_branch;
    issue(16'h1000, 8'h20, 8'h80, 8'h00, 8'h00, 8'h00, 1);
    chk(addr_mode, `MODE_REL);
    chk(branch_taken, 1);
    chk(next_pc, 16'h0f82);
    issue(16'h1000, 8'h20, 8'h80, 8'h00, 8'h00, 8'h00, 0);
    chk(branch_taken, 0);
    chk(next_pc, 16'h1002);
    issue(16'h1100, 8'h10, 8'h40, 8'h00, 8'h00, 8'h00, 0);
    chk(instr_group, `GRP_BIT);
    issue(16'h1200, 8'h00, 8'h40, 8'hfe, 8'h00, 8'h00, 1);
    chk(instr_length, 2'h3);
    chk(eff_addr, 16'h0040);
    chk(is_branch, 1'h1);
    chk(next_pc, 16'h1201);
  endtask
  task t_multiply;
    issue(16'h0500, `UNSIGNED_MULTIPLY_OP, 8'h00, 8'h00, 8'hff, 8'hff, 0);
    chk(is_multiply, 1);
    chk(acc_out, 8'h01);
    chk(idx_out, 8'hfe);
  endtask
  task finish_test;
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge clk_sys);
    #1;
    rst = 0;
    t_inherent;
    t_imm_dir;
    t_ext_ix2;
    t_indexed;
    t_branch;
    t_multiply;
    finish_test;
  end
  // Whole run needs well under a hundred cycles
  initial
  begin
    #100000;
    failures++;
    finish_test;
  end
endmodule // tb_cpu_addressing_mode_unit
